// File: verilog/acsp_defines.svh
// register offsets, field positions and timing counts for the serial configuration port
// assumes inclusion by the top module only
`ifndef ACSP_DEFINES_SVH
`define ACSP_DEFINES_SVH
`define ACSP_ADDR_CTRL        8'h00
`define ACSP_ADDR_SPEED_A     8'h02
`define ACSP_ADDR_PERF        8'h03
`define ACSP_ADDR_PWR_DRIVE   8'h45
`define ACSP_ADDR_HIFREQ_B    8'h4a
`define ACSP_ADDR_HIFREQ_A    8'h58
`define ACSP_ADDR_SPEED_B     8'hd5
`define ACSP_ADDR_SPEED_C     8'hd7
`define ACSP_ADDR_SPEED_D     8'hdb
`define ACSP_ADDR_DATA_FMT    8'h29
`define ACSP_ADDR_IF_SEL      8'h41
`define ACSP_ADDR_LOW_SPEED   8'hef
`define ACSP_BIT_READOUT      0
`define ACSP_BIT_SWRESET      1
`define ACSP_BIT_PDN_GLOBAL   2
`define ACSP_BIT_STBY         7
`define ACSP_BIT_DATA_FMT     4
`define ACSP_BIT_LVDS_SEL     7
`define ACSP_BIT_LOW_SPEED    4
`define ACSP_REG_RESET        8'h00
`define ACSP_WORD_BITS        5'h10
`define ACSP_HWRST_MIN_NS     10
`define ACSP_CLK_NS           8
`define ACSP_HWRST_CYC        ((`ACSP_HWRST_MIN_NS + `ACSP_CLK_NS - 1) / `ACSP_CLK_NS)
`endif

// File: verilog/acsp_pkg.sv
// types shared by the serial configuration port
// assumes the defines header sits beside it
package acsp_pkg;
  typedef logic [7:0] acsp_byte_t;
  // pin-strap select level, quantised into four bands outside this block
  typedef enum logic [1:0] {ACSP_SEL_ZERO, ACSP_SEL_3_8, ACSP_SEL_5_8, ACSP_SEL_FULL} acsp_sel_e;
  typedef enum logic [1:0] {ACSP_CFG_STRAP, ACSP_CFG_SERIAL} acsp_cfg_e;
endpackage

// File: verilog/acsp_fifo.sv
// synchronous FIFO with valid/ready on both sides
// assumes one clock and the block's active-low asynchronous reset
`timescale 1ns/1ps
module acsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic [AW:0]      nextCount;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;

  // empty from the occupancy count; full is registered from the next count so ready leaves on a flop
  assign nextCount = count + (AW+1)'(doWrite) - (AW+1)'(doRead);
  assign outValid  = (count != '0);
  assign outData  = mem[rdPtr];

  // storage has no reset, only pointers, count and ready do
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointer and occupancy bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
    end else begin
      if (doWrite) wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      if (doRead)  rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      count <= nextCount;
      inReady <= (nextCount != (AW+1)'(DEPTH));
    end
  end
endmodule

// File: verilog/acsp_serial_port.sv
// configuration and output logic of a dual-channel converter: serial port, resets, pin straps, output bus
// assumes pins arrive asynchronously and the serial clock is far slower than clk
`timescale 1ns/1ps
//
// Function
// - shift only while select is low
// - sample data on serial clock falling edge
// - commit word on every sixteenth falling edge
// - trailing partial word is dropped
// - many words per select low period
// - address byte first, then data byte
// - reset pulse restores all register defaults
// - software reset bit self clears
// - readback enable blocks register writes except to the control word
// - readback drives addressed register data out
// - readback output released when disabled
// - reset pin high selects pin strap mode
// - combined mode takes power state from pins
// - serial clock strap sets low speed
// - select level chooses format and interface
// - mode pins decode power and mux modes
// - mux mode puts both channels on B
// - CMOS: every bit each cycle, rising latch
// - registers zero after reset, unused bits zero
module acsp_serial_port #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              hwResetPin,
  input  wire logic              portSelectLow,
  input  wire logic              serialClock,
  input  wire logic              shiftIn,
  input  wire acsp_pkg::acsp_sel_e selectLevel,
  input  wire logic              modePin1,
  input  wire logic              modePin2,
  input  wire logic              modePin3,
  input  wire logic [11:0]       sampleA,
  input  wire logic [11:0]       sampleB,
  input  wire logic              sampleValid,
  output logic                   sampleReady,
  output logic                   readbackOut,
  output logic                   readbackOutEn,
  output logic [11:0]            chanABus,
  output logic                   chanABusEn,
  output logic [11:0]            chanBBus,
  output logic                   chanBBusEn,
  output logic                   outputClock,
  output logic                   offsetBinary,
  output logic                   lvdsSelect,
  output logic                   lowSpeed,
  output logic                   globalPowerDown,
  output logic                   chanAStandby,
  output logic                   muxMode,
  output logic                   strapMode
);
  import acsp_pkg::*;
`include "acsp_defines.svh"

  // two-flop synchronisers on every pin input
  logic [6:0] syncA;
  logic [6:0] syncB;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 7'h01;
      syncB <= 7'h01;
    end else begin
      syncA <= {modePin3, modePin2, modePin1, hwResetPin, shiftIn, serialClock, portSelectLow};
      syncB <= syncA;
    end
  end
  wire selLow  = ~syncB[0];
  wire sclkNow = syncB[1];
  wire sdi     = syncB[2];
  wire hwRst   = syncB[3];
  wire [2:0] modePins = syncB[6:4];

  // the strap level is a pin as well, so it gets the same two flops
  acsp_sel_e selSyncA;
  acsp_sel_e selSyncB;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      selSyncA <= ACSP_SEL_ZERO;
      selSyncB <= ACSP_SEL_ZERO;
    end else begin
      selSyncA <= selectLevel;
      selSyncB <= selSyncA;
    end
  end

  // falling-edge detect runs on the second stage only
  logic sclkPrev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sclkPrev <= 1'b0;
    else        sclkPrev <= sclkNow;
  end
  wire sclkFall = sclkPrev && !sclkNow && selLow;

  // shift register and bit counter
  logic [15:0] shiftReg;
  logic [3:0]  bitCount;
  logic [7:0]  regMem [256];
  logic        swResetPend;
  logic        hwRstSeen;
  wire [15:0]  nextShift = {shiftReg[14:0], sdi};
  wire         wordDone  = sclkFall && (bitCount == 4'hf);
  wire [7:0]   wordAddr  = nextShift[15:8];
  wire [7:0]   wordData  = nextShift[7:0];
  wire         readout   = regMem[`ACSP_ADDR_CTRL][`ACSP_BIT_READOUT];
  // control word stays writable in readback, else readback could never be turned off
  wire         regWrite  = wordDone && !hwRst && (!readout || wordAddr == `ACSP_ADDR_CTRL);
  wire         regClear  = swResetPend || (hwRst && !hwRstSeen);

  // partial word is discarded when select rises mid word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 16'h0000;
      bitCount <= 4'h0;
    end else if (!selLow) begin
      bitCount <= 4'h0;
    end else if (sclkFall) begin
      shiftReg <= nextShift;
      bitCount <= bitCount + 4'h1;
    end
  end

  // register file; any reset zeroes everything, system reset too so no unknown reaches the outputs
  // reset pin tied high is strap mode: registers held at defaults, unused
  always_ff @(posedge clk) begin
    if (!rst_n || regClear || hwRst) begin
      for (int i = 0; i < 256; i++) regMem[i] <= `ACSP_REG_RESET;
    end else if (regWrite) begin
      regMem[wordAddr] <= wordData;
    end
  end

  // software reset is a one-cycle pending flag that clears itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      swResetPend <= 1'b1;
      hwRstSeen   <= 1'b0;
    end else begin
      swResetPend <= regWrite && (wordAddr == `ACSP_ADDR_CTRL) && wordData[`ACSP_BIT_SWRESET];
      hwRstSeen   <= hwRst;
    end
  end

  // readback: address byte latched, data shifted out msb first on falling edges
  logic [7:0] rbShift;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rbShift       <= 8'h00;
      readbackOut   <= 1'b0;
      readbackOutEn <= 1'b0;
    end else begin
      readbackOutEn <= readout && !hwRst;
      if (sclkFall && bitCount == 4'h7) begin
        rbShift     <= regMem[nextShift[7:0]];
        readbackOut <= regMem[nextShift[7:0]][7];
      end else if (sclkFall && bitCount[3]) begin
        rbShift     <= {rbShift[6:0], 1'b0};
        readbackOut <= rbShift[6];
      end
    end
  end

  // configuration sources: straps when reset pin is high, registers otherwise; power state also from mode pins, mux mode from mode pins only
  wire strapNow = hwRst;
  wire regFmt   = regMem[`ACSP_ADDR_DATA_FMT][`ACSP_BIT_DATA_FMT];
  wire regLvds  = regMem[`ACSP_ADDR_IF_SEL][`ACSP_BIT_LVDS_SEL];
  wire regLow   = regMem[`ACSP_ADDR_LOW_SPEED][`ACSP_BIT_LOW_SPEED];
  wire regPdn   = regMem[`ACSP_ADDR_PWR_DRIVE][`ACSP_BIT_PDN_GLOBAL];
  wire regStby  = regMem[`ACSP_ADDR_PWR_DRIVE][`ACSP_BIT_STBY];
  wire strapFmt  = (selSyncB == ACSP_SEL_3_8) || (selSyncB == ACSP_SEL_5_8);
  wire strapLvds = (selSyncB == ACSP_SEL_5_8) || (selSyncB == ACSP_SEL_FULL);
  wire pinPdn   = (modePins == 3'b001);
  wire pinStby  = (modePins == 3'b101);
  wire pinMux   = (modePins == 3'b111);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      offsetBinary    <= 1'b0;
      lvdsSelect      <= 1'b0;
      lowSpeed        <= 1'b0;
      globalPowerDown <= 1'b0;
      chanAStandby    <= 1'b0;
      muxMode         <= 1'b0;
      strapMode       <= 1'b0;
    end else begin
      strapMode       <= strapNow;
      offsetBinary    <= strapNow ? strapFmt  : regFmt;
      lvdsSelect      <= strapNow ? strapLvds : regLvds;
      lowSpeed        <= strapNow ? sclkNow   : regLow;
      globalPowerDown <= pinPdn  || (!strapNow && regPdn);
      chanAStandby    <= pinStby || (!strapNow && regStby);
      muxMode         <= pinMux;
    end
  end

  // sample path: FIFO between sampler and output bus
  logic [23:0] fifoData;
  logic        fifoValid;
  logic        fifoReady;
  logic        muxPhase;
  wire         busStall = globalPowerDown;
  wire         fifoPop  = fifoValid && !busStall && outputClock && (!muxMode || muxPhase);
  acsp_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   ({sampleA, sampleB}),
    .inValid  (sampleValid),
    .inReady  (fifoReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );
  assign sampleReady = fifoReady;

  // output clock toggles each cycle; mux mode needs two phases per sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outputClock <= 1'b0;
      muxPhase    <= 1'b0;
      chanABus    <= 12'h000;
      chanBBus    <= 12'h000;
      chanABusEn  <= 1'b0;
      chanBBusEn  <= 1'b0;
    end else begin
      outputClock <= ~outputClock;
      chanABusEn  <= !globalPowerDown && !muxMode && !chanAStandby;
      chanBBusEn  <= !globalPowerDown;
      if (fifoValid && !busStall && outputClock) begin
        muxPhase <= muxMode ? ~muxPhase : 1'b0;
        chanABus <= fifoData[23:12];
        chanBBus <= (muxMode && !muxPhase) ? fifoData[23:12] : fifoData[11:0];
      end
    end
  end

  // checks
  property p_shift_gated;
    @(posedge clk) disable iff (!rst_n) !selLow |=> bitCount == 4'h0;
  endproperty
  a_shift_gated: assert property (p_shift_gated) else $error("bit count moved with select high");

  property p_fall_advances;
    @(posedge clk) disable iff (!rst_n) sclkFall && !wordDone |=> bitCount == $past(bitCount) + 4'h1;
  endproperty
  a_fall_advances: assert property (p_fall_advances) else $error("falling edge not counted");

  property p_commit;
    @(posedge clk) disable iff (!rst_n) regWrite && !regClear && wordAddr != `ACSP_ADDR_CTRL
      |=> regMem[$past(wordAddr)] == $past(wordData);
  endproperty
  a_commit: assert property (p_commit) else $error("word not committed");

  property p_partial;
    @(posedge clk) disable iff (!rst_n) selLow && !wordDone && sclkFall |-> !regWrite;
  endproperty
  a_partial: assert property (p_partial) else $error("partial word written");

  property p_swreset;
    @(posedge clk) disable iff (!rst_n) swResetPend |=> regMem[`ACSP_ADDR_CTRL] == 8'h00;
  endproperty
  a_swreset: assert property (p_swreset) else $error("soft reset did not clear");

  property p_block;
    @(posedge clk) disable iff (!rst_n) readout && wordAddr != `ACSP_ADDR_CTRL |-> !regWrite;
  endproperty
  a_block: assert property (p_block) else $error("write while readback on");

  property p_release;
    @(posedge clk) disable iff (!rst_n) !readout && !hwRst |=> !readbackOutEn;
  endproperty
  a_release: assert property (p_release) else $error("readback pin driven while off");

  property p_mux;
    @(posedge clk) disable iff (!rst_n) muxMode |=> !chanABusEn;
  endproperty
  a_mux: assert property (p_mux) else $error("channel A driven in mux mode");

  property p_strap_speed;
    @(posedge clk) disable iff (!rst_n) strapNow |=> lowSpeed == $past(sclkNow);
  endproperty
  a_strap_speed: assert property (p_strap_speed) else $error("strap low speed wrong");

  property p_strap_mode;
    @(posedge clk) disable iff (!rst_n) hwRst |=> strapMode;
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("reset pin high but not strapped");

  property p_strap_block;
    @(posedge clk) disable iff (!rst_n) hwRst |-> !regWrite;
  endproperty
  a_strap_block: assert property (p_strap_block) else $error("write taken while strapped");

  property p_strap_fmt;
    @(posedge clk) disable iff (!rst_n)
      strapNow |=> offsetBinary == ($past(selSyncB) inside {ACSP_SEL_3_8, ACSP_SEL_5_8});
  endproperty
  a_strap_fmt: assert property (p_strap_fmt) else $error("strap data format wrong");

  property p_strap_lvds;
    @(posedge clk) disable iff (!rst_n)
      strapNow |=> lvdsSelect == ($past(selSyncB) inside {ACSP_SEL_5_8, ACSP_SEL_FULL});
  endproperty
  a_strap_lvds: assert property (p_strap_lvds) else $error("strap interface select wrong");

  property p_hw_clear;
    @(posedge clk) disable iff (!rst_n) hwRst |=> regMem[$past(wordAddr)] == `ACSP_REG_RESET;
  endproperty
  a_hw_clear: assert property (p_hw_clear) else $error("reset pin did not clear register");

  property p_pdn_pin;
    @(posedge clk) disable iff (!rst_n) modePins == 3'b001 |=> globalPowerDown;
  endproperty
  a_pdn_pin: assert property (p_pdn_pin) else $error("power-down pins ignored");

  property p_stby_pin;
    @(posedge clk) disable iff (!rst_n) modePins == 3'b101 |=> chanAStandby;
  endproperty
  a_stby_pin: assert property (p_stby_pin) else $error("standby pins ignored");

  property p_mux_pin;
    @(posedge clk) disable iff (!rst_n) modePins == 3'b111 |=> muxMode;
  endproperty
  a_mux_pin: assert property (p_mux_pin) else $error("mux pins ignored");

  property p_mux_off;
    @(posedge clk) disable iff (!rst_n) modePins != 3'b111 |=> !muxMode;
  endproperty
  a_mux_off: assert property (p_mux_off) else $error("mux mode without its pin code");

  property p_serial_reach;
    @(posedge clk) disable iff (!rst_n) wordDone && !readout && !hwRst |-> regWrite;
  endproperty
  a_serial_reach: assert property (p_serial_reach) else $error("serial word lost in combined mode");

  property p_word_restart;
    @(posedge clk) disable iff (!rst_n) wordDone |=> bitCount == 4'h0;
  endproperty
  a_word_restart: assert property (p_word_restart) else $error("next word does not start fresh");

  property p_msb_first;
    @(posedge clk) disable iff (!rst_n) sclkFall |=> shiftReg == {$past(shiftReg[14:0]), $past(sdi)};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("shift order wrong");

  property p_sw_pulse;
    @(posedge clk) disable iff (!rst_n) swResetPend |=> !swResetPend;
  endproperty
  a_sw_pulse: assert property (p_sw_pulse) else $error("software reset did not self clear");

  property p_oe_on;
    @(posedge clk) disable iff (!rst_n) readout && !hwRst |=> readbackOutEn;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("readback pin not driven");

  property p_chanb_en;
    @(posedge clk) disable iff (!rst_n) globalPowerDown |=> !chanBBusEn;
  endproperty
  a_chanb_en: assert property (p_chanb_en) else $error("bus driven while powered down");

  property p_outclk;
    @(posedge clk) disable iff (!rst_n) outputClock |=> !outputClock;
  endproperty
  a_outclk: assert property (p_outclk) else $error("output clock stuck high");

  property p_clear_any;
    @(posedge clk) disable iff (!rst_n) regClear |=> !readout;
  endproperty
  a_clear_any: assert property (p_clear_any) else $error("control word not zero after reset");
endmodule

// File: tb/acsp_ctrl_model.sv
// controller model that drives the serial configuration port
// assumes the block samples the serial pins with its own fast clock
`timescale 1ns/1ps
module acsp_ctrl_model (
  input  wire logic       clk,
  input  wire logic       sdo,
  output logic            selLow,
  output logic            sclk,
  output logic            sdi,
  output logic [7:0]      rdByte,
  output logic            rdDone
);
  initial begin
    selLow = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
    rdByte = 8'h00;
    rdDone = 1'b0;
  end

  // one select-low frame, msb first; 5 clk per phase stays well under 20 MHz
  task automatic frame(input logic [31:0] bits, input int n, input logic rd);
    logic [31:0] cap;
    cap = 32'h0;
    @(negedge clk);
    selLow = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = bits[i];
      repeat (5) @(negedge clk);
      cap = {cap[30:0], sdo};
      sclk = 1'b0;
      repeat (5) @(negedge clk);
    end
    sclk = 1'b1;
    repeat (5) @(negedge clk);
    selLow = 1'b1;
    sdi = ~sdi;  // released line shows no stale value
    rdByte = cap[7:0];
    rdDone = rd;
    @(negedge clk);
    rdDone = 1'b0;
  endtask

  // clock and data wiggle with select high; must be ignored
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      sdi = i[0];
      sclk = ~sclk;
      repeat (5) @(negedge clk);
    end
    sclk = 1'b1;
  endtask
endmodule

// File: tb/adc_config_serial_port_test.sv
// self-checking bench for the serial configuration port
// assumes the controller model file is compiled first
`timescale 1ns/1ps
module adc_config_serial_port_test;
  import acsp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hwResetPin = 1'b0;
  acsp_sel_e selectLevel = ACSP_SEL_ZERO;
  logic [2:0] pins = 3'h0;
  logic [11:0] sampleA = 12'h000;
  logic [11:0] sampleB = 12'h000;
  logic sampleValid = 1'b0;
  logic sampleReady, readbackOut, readbackOutEn, chanABusEn, chanBBusEn, outputClock;
  logic offsetBinary, lvdsSelect, lowSpeed, globalPowerDown, chanAStandby, muxMode, strapMode;
  logic [11:0] chanABus, chanBBus, a0, b0;
  logic selLow, sclk, sdi, rdDone, sdoWire;
  logic [7:0] rdByte, v1, v2, v3;
  logic [15:0] expQ[$];
  int mismatches = 0;
  int checksDone = 0;
  int n;

  // no pull on the readback pin, so a released pin reads as z and fails a compare
  assign sdoWire = readbackOutEn ? readbackOut : 1'bz;

  initial begin
    forever #4 clk = ~clk;
  end

  acsp_serial_port #(.FIFO_DEPTH(32)) u_dut (.clk(clk), .rst_n(rst_n), .hwResetPin(hwResetPin),
    .portSelectLow(selLow), .serialClock(sclk), .shiftIn(sdi), .selectLevel(selectLevel),
    .modePin1(pins[2]), .modePin2(pins[1]), .modePin3(pins[0]), .sampleA(sampleA), .sampleB(sampleB),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .readbackOut(readbackOut),
    .readbackOutEn(readbackOutEn), .chanABus(chanABus), .chanABusEn(chanABusEn), .chanBBus(chanBBus),
    .chanBBusEn(chanBBusEn), .outputClock(outputClock), .offsetBinary(offsetBinary),
    .lvdsSelect(lvdsSelect), .lowSpeed(lowSpeed), .globalPowerDown(globalPowerDown),
    .chanAStandby(chanAStandby), .muxMode(muxMode), .strapMode(strapMode));

  acsp_ctrl_model u_ctl (.clk(clk), .sdo(sdoWire), .selLow(selLow), .sclk(sclk), .sdi(sdi),
    .rdByte(rdByte), .rdDone(rdDone));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ctl.frame({16'h0, a, d}, 16, 1'b0);
  endtask

  // expected byte is queued; the monitor compares when the frame ends
  // dummy data 01 keeps readback on when the control word itself is read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({8'h00, e});
    u_ctl.frame({16'h0, a, 8'h01}, 16, 1'b1);
  endtask

  task automatic hw_rst();
    hwResetPin = 1'b1;
    repeat (3) @(negedge clk);
    hwResetPin = 1'b0;
    repeat (6) @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // readback monitor
  always @(posedge rdDone) begin
    chk({8'h00, rdByte}, expQ.pop_front());
  end

  // watchdog, about eight times the expected run
  initial begin
    #400000;
    mismatches++;
    print_verdict();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    v1 = 8'($urandom(89));
    hw_rst();
    wr(8'h00, 8'h01);
    rd(8'h45, 8'h00);
    rd(8'h00, 8'h01);
    $display("test defaults done");
    hw_rst();
    v1 = 8'($urandom);
    v2 = 8'($urandom);
    v3 = 8'($urandom);
    u_ctl.frame({8'h02, v1, 8'hd5, v2}, 32, 1'b0);
    u_ctl.frame({1'b0, 8'hdb, v3, 8'h58, 7'h7f}, 31, 1'b0);
    u_ctl.noise();
    wr(8'h00, 8'h01);
    rd(8'h02, v1);
    rd(8'hd5, v2);
    rd(8'hdb, v3);
    rd(8'h58, 8'h00);
    wr(8'h02, ~v1);
    rd(8'h02, v1);
    wr(8'h00, 8'h00);
    chk({15'h0, readbackOutEn}, 16'h0);
    wr(8'h02, ~v1);
    wr(8'h00, 8'h01);
    rd(8'h02, ~v1);
    hw_rst();
    chk({15'h0, readbackOutEn}, 16'h0);
    wr(8'h00, 8'h01);
    rd(8'h02, 8'h00);
    $display("test serial writes done");
    hw_rst();
    wr(8'h4a, 8'h01);
    wr(8'h03, 8'h03);
    wr(8'h02, 8'h40);
    wr(8'hd5, 8'h18);
    wr(8'hd7, 8'h0c);
    wr(8'hdb, 8'h20);
    wr(8'h00, 8'h01);
    rd(8'hd7, 8'h0c);
    wr(8'h00, 8'h00);
    wr(8'h00, 8'h02);
    wr(8'h00, 8'h01);
    rd(8'h03, 8'h00);
    rd(8'h4a, 8'h00);
    rd(8'hdb, 8'h00);
    rd(8'h00, 8'h01);
    hw_rst();
    $display("test software reset done");
    for (int c = 0; c < 8; c++) begin
      pins = c[2:0];
      repeat (8) @(negedge clk);
      chk({15'h0, globalPowerDown}, {15'h0, c == 4});
      chk({15'h0, chanAStandby}, {15'h0, c == 5});
      chk({15'h0, muxMode}, {15'h0, c == 7});
      if (c == 7) begin
        chk({15'h0, chanABusEn}, 16'h0);
      end
    end
    $display("test mode pins done");
    // powered down holds the fifo, so it fills until it refuses
    pins = 3'h4;
    repeat (8) @(negedge clk);
    n = 0;
    while (n < 40) begin
      @(negedge clk);
      if (sampleReady !== 1'b1) begin
        break;
      end
      sampleValid = 1'b1;
      sampleA = 12'($urandom);
      sampleB = 12'($urandom);
      if (n == 0) begin
        a0 = sampleA;
        b0 = sampleB;
      end
      n++;
    end
    sampleValid = 1'b0;
    chk(16'(n), 16'd32);
    pins = 3'h0;
    for (int i = 0; i < 100 && chanABus !== a0; i++) begin
      @(negedge clk);
    end
    chk({4'h0, chanABus}, {4'h0, a0});
    chk({4'h0, chanBBus}, {4'h0, b0});
    chk({15'h0, chanBBusEn}, 16'h1);
    v2 = {7'h0, outputClock};
    @(negedge clk);
    chk({15'h0, outputClock}, {15'h0, ~v2[0]});
    repeat (100) @(negedge clk);
    chk({15'h0, sampleReady}, 16'h1);
    $display("test sample fifo done");
    hwResetPin = 1'b1;
    for (int l = 0; l < 4; l++) begin
      for (int s = 0; s < 2; s++) begin
        selectLevel = acsp_sel_e'(l);
        u_ctl.sclk = s[0];
        repeat (8) @(negedge clk);
        chk({15'h0, strapMode}, 16'h1);
        chk({15'h0, lowSpeed}, {15'h0, s[0]});
        chk({15'h0, offsetBinary}, {15'h0, l == 1 || l == 2});
        chk({15'h0, lvdsSelect}, {15'h0, l[1]});
      end
    end
    hwResetPin = 1'b0;
    $display("test pin strap done");
    print_verdict();
  end
endmodule
